// File: hw/lp_sdram_regs.svh
// timing counts and sizes for the self refresh / mode read block
// assumes a 100 MHz system clock sampling the link clock
`ifndef LP_SDRAM_REGS_SVH
`define LP_SDRAM_REGS_SVH
`define CLK_PERIOD_NS 10
// minimum self refresh residence, ns
`define T_CKESR_NS 15
`define T_CKESR_CYC ((`T_CKESR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// command to first data beat, in link clock periods
`define READ_LATENCY 3
`define MRR_BEATS 4
`define MRR_CMD_CYCLES 2
`define BANK_COUNT 4
// internal refresh interval in self refresh, system cycles
`define SELF_REF_INTERVAL 4000
`endif

// File: hw/lp_sdram_pkg.sv
// types shared by the self refresh / mode register read block
// assumes nothing of its surroundings
package lp_sdram_pkg;
	typedef struct packed {
		logic cke;
		logic cs_n;
		logic [9:0] ca;
	} cmd_pins_t;
	typedef struct packed {
		logic [7:0] addr;
		logic valid;
	} mrr_req_t;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SELF_REF,
		ST_EXIT
	} power_state_t;
endpackage : lp_sdram_pkg

// File: hw/mrr_burst.sv
// mode register read data burst: latency, four beats, strobe toggling
// assumes link_rise pulses once per sampled link clock rising edge
`timescale 1ns/10ps
`include "lp_sdram_regs.svh"
module mrr_burst #(
	parameter int DQ_WIDTH = 16,
	parameter int LATENCY = `READ_LATENCY
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic link_rise,
	input wire logic link_fall,
	input wire logic start,
	input wire logic [7:0] reg_data,
	input wire logic reg_known,
	output logic [DQ_WIDTH-1:0] dq_out,
	output logic dq_oe_n,
	output logic dqs_out,
	output logic dqs_oe_n,
	output logic busy
);
	import lp_sdram_pkg::*;
	logic [3:0] lat_q, lat_d;
	logic [3:0] half_q, half_d;
	logic run_q, run_d;
	logic [7:0] data_q, data_d;
	logic known_q, known_d;
	logic [DQ_WIDTH-1:0] dq_q, dq_d;
	logic dqs_q, dqs_d;
	logic [DQ_WIDTH-1:0] filler_q, filler_d;
	// ==========================================================
	// burst sequencing
	always_comb begin
		lat_d = lat_q;
		half_d = half_q;
		run_d = run_q;
		data_d = data_q;
		known_d = known_q;
		dq_d = dq_q;
		dqs_d = dqs_q;
		filler_d = filler_q;
		if (start) begin
			lat_d = 4'(LATENCY);
			run_d = 1'b0;
			data_d = reg_data;
			known_d = reg_known;
			half_d = 4'h0;
		end else if (lat_q != 4'h0 && link_rise) begin
			lat_d = lat_q - 4'h1;
			if (lat_q == 4'h1) begin
				run_d = 1'b1;
			end
		end else if (run_q && (link_rise || link_fall)) begin
			// filler is arbitrary but defined data on other beats
			filler_d = {filler_q[DQ_WIDTH-2:0], ~filler_q[DQ_WIDTH-1]};
			dqs_d = ~dqs_q;
			if (half_q == 4'h0) begin
				// first beat carries the register if reg_known was set, else all filler; upper lanes filler
				dq_d = filler_q;
				if (known_q) begin
					dq_d[7:0] = data_q;
				end
			end else begin
				dq_d = filler_q;
			end
			half_d = half_q + 4'h1;
			// edge after the last beat parks the strobe low, ends drive
			if (half_q == 4'(`MRR_BEATS)) begin
				run_d = 1'b0;
				dqs_d = 1'b0;
			end
		end
	end
	always_ff @(posedge clock) begin
		if (srst) begin
			lat_q <= 4'h0;
			half_q <= 4'h0;
			run_q <= 1'b0;
			data_q <= 8'h00;
			known_q <= 1'b0;
			dq_q <= '0;
			dqs_q <= 1'b0;
			filler_q <= '0;
		end else begin
			lat_q <= lat_d;
			half_q <= half_d;
			run_q <= run_d;
			data_q <= data_d;
			known_q <= known_d;
			dq_q <= dq_d;
			dqs_q <= dqs_d;
			filler_q <= filler_d;
		end
	end
	assign dq_out = dq_q;
	assign dqs_out = dqs_q;
	assign dq_oe_n = ~run_q;
	assign dqs_oe_n = ~run_q;
	assign busy = run_q || lat_q != 4'h0;
endmodule : mrr_burst

// File: hw/lp_sdram_ctrl.sv
// device side command decode: self refresh, bank mask, mode register read
// assumes host drives link clock and command pins; all are asynchronous
`timescale 1ns/10ps
`include "lp_sdram_regs.svh"
module lp_sdram_ctrl #(
	parameter int DQ_WIDTH = 16,
	parameter int SELF_REF_INTERVAL = `SELF_REF_INTERVAL
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic link_clk,
	input wire lp_sdram_pkg::cmd_pins_t pins,
	input wire logic [`BANK_COUNT-1:0] bank_mask,
	input wire logic [7:0] segment_mask,
	input wire logic [7:0] reg_read_data,
	input wire logic reg_read_known,
	output lp_sdram_pkg::mrr_req_t reg_read_req,
	output logic [DQ_WIDTH-1:0] dq_out,
	output logic dq_oe_n,
	output logic dqs_out,
	output logic dqs_oe_n,
	output logic [`BANK_COUNT-1:0] bank_refresh,
	output logic [7:0] segment_refresh,
	output logic in_self_refresh,
	output logic exit_pending
);
	import lp_sdram_pkg::*;
	// ==========================================================
	// pin synchronisers
	logic clk_s1_q, clk_s2_q, clk_s3_q;
	cmd_pins_t pins_s1_q, pins_s2_q;
	always_ff @(posedge clock) begin
		clk_s1_q <= link_clk;
		clk_s2_q <= clk_s1_q;
		clk_s3_q <= clk_s2_q;
		pins_s1_q <= pins;
		pins_s2_q <= pins_s1_q;
	end
	// edges found from the second stage onward only
	logic link_rise, link_fall;
	assign link_rise = clk_s2_q && !clk_s3_q;
	assign link_fall = !clk_s2_q && clk_s3_q;
	// ==========================================================
	// command decode at link rising edges, upper read address at falling edges
	logic prev_cke_q, prev_cke_d;
	logic mrr_half_q, mrr_half_d;
	logic [5:0] mrr_lo_q, mrr_lo_d;
	mrr_req_t req_q, req_d;
	logic sr_entry, mrr_rise;
	logic burst_busy;
	power_state_t st_q, st_d;
	assign sr_entry = link_rise && prev_cke_q && !pins_s2_q.cke
		&& !pins_s2_q.cs_n && pins_s2_q.ca[2:0] == 3'b100;
	assign mrr_rise = link_rise && pins_s2_q.cke && !pins_s2_q.cs_n
		&& pins_s2_q.ca[3:0] == 4'b1000 && st_q == ST_IDLE;
	always_comb begin
		prev_cke_d = prev_cke_q;
		mrr_half_d = mrr_half_q;
		mrr_lo_d = mrr_lo_q;
		req_d = req_q;
		req_d.valid = 1'b0;
		if (link_rise) begin
			prev_cke_d = pins_s2_q.cke;
		end
		// the fall half of the command carries the upper address bits
		if (link_fall && mrr_half_q) begin
			mrr_half_d = 1'b0;
			req_d.addr = {pins_s2_q.ca[1:0], mrr_lo_q};
			req_d.valid = 1'b1;
		end else if (mrr_rise && !burst_busy) begin
			// a new read while one runs is dropped, not truncating it
			mrr_half_d = 1'b1;
			mrr_lo_d = pins_s2_q.ca[9:4];
		end
	end
	always_ff @(posedge clock) begin
		if (srst) begin
			prev_cke_q <= 1'b0;
			mrr_half_q <= 1'b0;
			mrr_lo_q <= 6'h00;
			req_q <= '0;
		end else begin
			prev_cke_q <= prev_cke_d;
			mrr_half_q <= mrr_half_d;
			mrr_lo_q <= mrr_lo_d;
			req_q <= req_d;
		end
	end
	assign reg_read_req = req_q;
	// ==========================================================
	// self refresh state and internal refresh timer
	logic [15:0] timer_q, timer_d;
	logic [15:0] exit_cnt_q, exit_cnt_d;
	logic refresh_now;
	always_comb begin
		st_d = st_q;
		timer_d = timer_q;
		exit_cnt_d = exit_cnt_q;
		refresh_now = 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (sr_entry) begin
					st_d = ST_SELF_REF;
					timer_d = 16'(`T_CKESR_CYC);
				end
			end
			ST_SELF_REF: begin
				// runs from the system clock: link clock may be stopped
				if (timer_q == 16'h0000) begin
					refresh_now = 1'b1;
					timer_d = 16'(SELF_REF_INTERVAL);
				end else begin
					timer_d = timer_q - 16'h0001;
				end
				// only cke is looked at here
				if (link_rise && pins_s2_q.cke) begin
					st_d = ST_EXIT;
					exit_cnt_d = 16'(`T_CKESR_CYC);
				end
			end
			ST_EXIT: begin
				// exit interval counted from first edge with cke high
				if (exit_cnt_q != 16'h0000) begin
					exit_cnt_d = exit_cnt_q - 16'h0001;
				end else begin
					st_d = ST_IDLE;
				end
				if (sr_entry) begin
					st_d = ST_SELF_REF;
					timer_d = 16'(`T_CKESR_CYC);
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end
	always_ff @(posedge clock) begin
		if (srst) begin
			st_q <= ST_IDLE;
			timer_q <= 16'h0000;
			exit_cnt_q <= 16'h0000;
		end else begin
			st_q <= st_d;
			timer_q <= timer_d;
			exit_cnt_q <= exit_cnt_d;
		end
	end
	// ==========================================================
	// per bank refresh gating; power down never refreshes
	logic [`BANK_COUNT-1:0] bank_ref_q, bank_ref_d;
	logic [7:0] seg_ref_q, seg_ref_d;
	genvar b;
	generate
		for (b = 0; b < `BANK_COUNT; b++) begin : g_bank
			assign bank_ref_d[b] = refresh_now && !bank_mask[b];
		end
	endgenerate
	assign seg_ref_d = (refresh_now && bank_ref_d != '0) ?
		~segment_mask : 8'h00;
	always_ff @(posedge clock) begin
		if (srst) begin
			bank_ref_q <= '0;
			seg_ref_q <= 8'h00;
		end else begin
			bank_ref_q <= bank_ref_d;
			seg_ref_q <= seg_ref_d;
		end
	end
	assign bank_refresh = bank_ref_q;
	assign segment_refresh = seg_ref_q;
	assign in_self_refresh = st_q == ST_SELF_REF;
	assign exit_pending = st_q == ST_EXIT;
	// ==========================================================
	// read burst
	mrr_burst #(
		.DQ_WIDTH(DQ_WIDTH),
		.LATENCY(`READ_LATENCY)
	) u_burst (
		.clock(clock),
		.srst(srst),
		.link_rise(link_rise),
		.link_fall(link_fall),
		.start(req_q.valid),
		.reg_data(reg_read_data),
		.reg_known(reg_read_known),
		.dq_out(dq_out),
		.dq_oe_n(dq_oe_n),
		.dqs_out(dqs_out),
		.dqs_oe_n(dqs_oe_n),
		.busy(burst_busy)
	);
endmodule : lp_sdram_ctrl

// File: verif/sdram_sr_monitor.sv
// ports-only checker for the self refresh / mode read block
// assumes bind onto lp_sdram_ctrl
`timescale 1ns/10ps
`include "lp_sdram_regs.svh"
module sdram_sr_monitor (
	input wire logic clock,
	input wire logic srst,
	input wire lp_sdram_pkg::mrr_req_t reg_read_req,
	input wire logic [`BANK_COUNT-1:0] bank_mask,
	input wire logic [7:0] segment_mask,
	input wire logic dq_oe_n,
	input wire logic [`BANK_COUNT-1:0] bank_refresh,
	input wire logic [7:0] segment_refresh,
	input wire logic in_self_refresh,
	input wire logic exit_pending
);
	import lp_sdram_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	// ==========================
	// sequences
	sequence s_drive;
		!dq_oe_n [*8];
	endsequence
	sequence s_exit;
		exit_pending [*3] ##1 !exit_pending;
	endsequence
	// ==========================
	// properties
	a_req_single: assert property (
		reg_read_req.valid |=> !reg_read_req.valid)
		else $error("read request longer than one cycle");
	a_sr_quiet: assert property (
		in_self_refresh |-> !reg_read_req.valid && dq_oe_n)
		else $error("activity while in self refresh");
	a_req_burst: assert property (
		$rose(reg_read_req.valid) |-> ##[1:60] !dq_oe_n)
		else $error("no data after read request");
	a_burst_len: assert property (
		$fell(dq_oe_n) |-> s_drive ##[12:32] dq_oe_n)
		else $error("burst length wrong");
	a_mask_gate: assert property (
		|bank_refresh |-> !(|(bank_refresh & bank_mask)))
		else $error("masked bank refreshed");
	a_seg_gate: assert property (
		|bank_refresh |-> segment_refresh == ~segment_mask)
		else $error("segment refresh mismatch");
	a_no_pd_refresh: assert property (
		|bank_refresh |-> in_self_refresh || $past(in_self_refresh))
		else $error("refresh outside self refresh");
	a_first_ref: assert property (
		$rose(in_self_refresh) && !(&bank_mask)
		|-> ##[1:6] |bank_refresh)
		else $error("no refresh soon after entry");
	a_exit_len: assert property ($rose(exit_pending) |-> s_exit)
		else $error("exit interval length wrong");
endmodule : sdram_sr_monitor

bind lp_sdram_ctrl sdram_sr_monitor mon_u (.clock(clock), .srst(srst),
	.reg_read_req(reg_read_req), .bank_mask(bank_mask),
	.segment_mask(segment_mask), .dq_oe_n(dq_oe_n),
	.bank_refresh(bank_refresh), .segment_refresh(segment_refresh),
	.in_self_refresh(in_self_refresh), .exit_pending(exit_pending));

// File: verif/host_model.sv
// host controller model: link clock and command pins
// assumes the system clock; link clock only runs inside tasks
`timescale 1ns/10ps
module host_model (
	input wire logic clock,
	output logic link_clk,
	output lp_sdram_pkg::cmd_pins_t pins
);
	import lp_sdram_pkg::*;
	initial begin
		link_clk = 1'b0;
		pins = '{1'b1, 1'b1, 10'h3ff};
	end
	// ==========================
	// one link period, 80 ns
	task cyc(input logic ck, input logic cs, input logic [9:0] r,
		input logic [9:0] f);
		pins = '{ck, cs, r};
		repeat (2) @(negedge clock);
		link_clk = 1'b1;
		repeat (2) @(negedge clock);
		pins.ca = f;
		repeat (2) @(negedge clock);
		link_clk = 1'b0;
		repeat (2) @(negedge clock);
	endtask : cyc
	// deselected lines flip so stale values never pass
	task nop(input int n, input logic ck);
		repeat (n) cyc(ck, 1'b1, ~pins.ca, pins.ca);
	endtask : nop
	task mrr(input logic [7:0] a);
		cyc(1'b1, 1'b0, {a[5:0], 4'b1000}, {8'h00, a[7:6]});
		nop(10, 1'b1);
	endtask : mrr
	task sr_enter;
		nop(2, 1'b1);
		cyc(1'b0, 1'b0, 10'h004, 10'h000);
		nop(1, 1'b0);
	endtask : sr_enter
	task sr_exit;
		nop(2, 1'b0);
		nop(3, 1'b1);
		cyc(1'b1, 1'b0, 10'h00c, 10'h000);
		nop(2, 1'b1);
	endtask : sr_exit
endmodule : host_model

// File: verif/tb_lp_sdram_ctrl.sv
// self-checking bench for lp_sdram_ctrl
// assumes host_model drives the link side
`timescale 1ns/10ps
module tb_lp_sdram_ctrl;
	import lp_sdram_pkg::*;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic link_clk;
	cmd_pins_t pins;
	logic [3:0] bank_mask = 4'h0;
	logic [7:0] segment_mask = 8'h00;
	logic [7:0] reg_read_data = 8'h00;
	logic reg_read_known = 1'b1;
	mrr_req_t reg_read_req;
	logic [15:0] dq_out;
	logic dq_oe_n, dqs_out, dqs_oe_n, in_self_refresh, exit_pending;
	logic [3:0] bank_refresh;
	logic [7:0] segment_refresh;
	int n_errors = 0;
	int tests_run = 0;
	always #5 clock = ~clock;
	host_model host_u (.clock(clock), .link_clk(link_clk), .pins(pins));
	// short interval keeps the run small
	lp_sdram_ctrl #(.SELF_REF_INTERVAL(20)) dut_u (.clock(clock),
		.srst(srst), .link_clk(link_clk), .pins(pins),
		.bank_mask(bank_mask), .segment_mask(segment_mask),
		.reg_read_data(reg_read_data), .reg_read_known(reg_read_known),
		.reg_read_req(reg_read_req), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
		.dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n),
		.bank_refresh(bank_refresh), .segment_refresh(segment_refresh),
		.in_self_refresh(in_self_refresh), .exit_pending(exit_pending));
	// ==========================
	// reporting
	task chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task stop_test;
		$display("errors=%0d checks=%0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test
	task bound(input int i);
		if (i >= 400) begin
			n_errors++;
			stop_test();
		end
	endtask : bound
	// ==========================
	// scenarios
	task t_mrr(input logic [7:0] a, input logic [7:0] d, input logic k);
		int i;
		int edges;
		logic last;
		logic [7:0] first;
		@(negedge clock);
		reg_read_data = d;
		reg_read_known = k;
		edges = 0;
		last = 1'b0;
		fork
			host_u.mrr(a);
			begin
				for (i = 0; i < 400 && reg_read_req.valid !== 1'b1; i++) begin
					@(negedge clock);
				end
				bound(i);
				chk({8'h00, reg_read_req.addr}, {8'h00, a});
				for (i = 0; i < 400 && dq_oe_n !== 1'b0; i++) begin
					@(negedge clock);
				end
				bound(i);
				first = 8'h00;
				for (i = 0; i < 400 && dqs_oe_n !== 1'b1; i++) begin
					// data and strobe move together on the first beat
					if (dqs_out !== last && edges == 0) begin
						first = dq_out[7:0];
					end
					if (dqs_out !== last) edges++;
					last = dqs_out;
					@(negedge clock);
				end
				bound(i);
				if (dqs_out !== last) edges++;
			end
		join
		chk(16'(edges), 16'h0004);
		if (k) chk({8'h00, first}, {8'h00, d});
	endtask : t_mrr
	task t_self_ref(input logic [3:0] bm, input logic [7:0] sm);
		int i;
		int reqs;
		logic [3:0] banks;
		logic [7:0] segs;
		@(negedge clock);
		bank_mask = bm;
		segment_mask = sm;
		banks = 4'h0;
		segs = 8'h00;
		reqs = 0;
		host_u.sr_enter();
		for (i = 0; i < 400 && in_self_refresh !== 1'b1; i++) begin
			@(negedge clock);
		end
		bound(i);
		fork
			host_u.cyc(1'b0, 1'b0, 10'h018, 10'h000);
			for (i = 0; i < 100; i++) begin
				@(negedge clock);
				banks |= bank_refresh;
				segs |= segment_refresh;
				if (reg_read_req.valid !== 1'b0) reqs++;
			end
		join
		chk(16'(reqs), 16'h0000);
		chk({12'h000, banks}, {12'h000, ~bm});
		chk({8'h00, segs}, {8'h00, ~sm});
		fork
			host_u.sr_exit();
			begin
				for (i = 0; i < 400 && exit_pending !== 1'b1; i++) begin
					@(negedge clock);
				end
				bound(i);
				chk({15'h0000, in_self_refresh}, 16'h0000);
			end
		join
		chk({15'h0000, exit_pending}, 16'h0000);
	endtask : t_self_ref
	initial begin
		repeat (4) @(negedge clock);
		srst = 1'b0;
		repeat (4) @(negedge clock);
		host_u.nop(2, 1'b1);
		t_mrr(8'h05, 8'ha5, 1'b1);
		t_mrr(8'hc3, 8'h3c, 1'b1);
		t_mrr(8'h7f, 8'h00, 1'b0);
		t_self_ref(4'h5, 8'h0f);
		t_self_ref(4'h0, 8'hf0);
		t_mrr(8'h01, 8'h5a, 1'b1);
		stop_test();
	end
endmodule : tb_lp_sdram_ctrl
